// >>> logic/irq_ctl_pkg.sv
/*
  Shared constants and types of the interrupt control and status block:
  register offsets, field positions, reset values and the control states.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`default_nettype none

package irq_ctl_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] RELOAD_OFF = 8'h08;
  localparam logic [7:0] FLAG_OFF = 8'h0C;
  localparam logic [7:0] MASK_OFF = 8'h10;

  // Control word layout
  localparam int SHADOW_BIT = 16;
  localparam int MULTI_VEC_BIT = 12;
  localparam int TRIG_LSB = 8;
  localparam int EDGE_LSB = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0001_171F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status word layout
  localparam int PRI_LSB = 8;
  localparam int VEC_LSB = 0;

  // External inputs and their fixed vector and priority
  localparam int NUM_EXT = 5;
  localparam logic [5:0] EXT_VEC_BASE = 6'h03;
  localparam logic [2:0] EXT_PRIORITY = 3'h4;
  localparam logic [5:0] SINGLE_VEC = 6'h00;
  localparam logic [2:0] PRI_NONE = 3'h0;

  // Event flag bits
  localparam int EV_W = 3;
  localparam int EV_PRESENT = 0;
  localparam int EV_PROX = 1;
  localparam int EV_EXT = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEFER = 2'b01,
    ST_PRESENT = 2'b10
  } ctl_state_t;

endpackage : irq_ctl_pkg

`default_nettype wire

// >>> logic/prox_timer_if.sv
/*
  Connection between the interrupt controller and its proximity timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface prox_timer_if;
  logic start;
  logic [31:0] reload;
  logic busy;
  logic done;

  modport ctrl (output start, output reload, input busy, input done);
  modport tmr (input start, input reload, output busy, output done);
endinterface : prox_timer_if

`default_nettype wire

// >>> logic/ext_edge_detect.sv
/*
  Two-stage synchroniser and polarity-selected edge detector for the
  external interrupt pins. Assumes pins are asynchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ext_edge_detect (
  input wire logic ref_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [4:0] pin_i, // Raw external pins
  input wire logic [4:0] pol_i, // One selects rising edge
  output logic [4:0] edge_o // One-cycle edge pulses
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] prev;
    logic [4:0] hit;
  } edge_state_t;

  edge_state_t r, n;
  logic [4:0] hit_c;

  // Per-pin edge choice; only the second stage is looked at
  genvar i;
  generate
    for (i = 0; i < irq_ctl_pkg::NUM_EXT; i++) begin : g_pin
      assign hit_c[i] = pol_i[i] ? (r.s2[i] & ~r.prev[i]) :
                                   (~r.s2[i] & r.prev[i]);
    end
  endgenerate

  // Next state
  always_comb begin
    n = r;
    n.s1 = pin_i;
    n.s2 = r.s1;
    n.prev = r.s2;
    n.hit = hit_c;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign edge_o = r.hit;

endmodule : ext_edge_detect

`default_nettype wire

// >>> logic/prox_timer.sv
/*
  Interrupt proximity down-counter. Loads the reload word on start and
  counts one per clock; pulses done when the count reaches zero.
  Assumes start is only raised while the timer is idle.
*/
`timescale 1ns/1ps
`default_nettype none

module prox_timer (
  input wire logic ref_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  prox_timer_if.tmr tif // Start, reload, busy, done
);

  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } tmr_state_t;

  tmr_state_t r, n;

  // Load, count down and expire
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (tif.start && !r.busy) begin
      n.cnt = tif.reload;
      n.busy = 1'b1;
    end else if (r.busy) begin
      n.cnt = r.cnt - 32'h0000_0001;
      if (r.cnt == 32'h0000_0001) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tif.busy = r.busy;
  assign tif.done = r.done;

endmodule : prox_timer

`default_nettype wire

// >>> logic/irq_control_and_status.sv
/*
  Control and status registers of a vectored interrupt controller, with
  external edge inputs, a proximity timer that defers low-priority
  requests, an AXI4-Lite slave and a maskable event interrupt.
  Assumes one clock, a peripheral request that drops when acknowledged,
  and a core that acknowledges each presented request.
  Status fields follow each presentation in either mode, but only the
  single-vector reading is meaningful to software.
*/
// Function
// - With the shadow bit set, the single vector goes out with a shadow set, otherwise without.
// - The vector-mode bit selects multi-vector mode when one and single-vector when zero.
// - A zero trigger level disables the timer, a level N lets priorities up to N start it.
// - Each of five external inputs fires on rising edge with its bit one, falling edge with zero.
// - Unused control bits read zero and ignore writes.
// - Status holds priority in bits 10 to 8 and vector in 5 to 0, zero at reset, rest zero.
// - The status priority field shows the priority of the latest presented interrupt.
// - The status vector field shows the source's vector, also in single-vector mode where the core gets vector zero.
// - A qualifying event loads the timer from the 32-bit reload register.
`timescale 1ns/1ps
`default_nettype none

module irq_control_and_status (
  input wire logic ref_clk_i, // System clock, 10 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [7:0] awaddr_i, // AXI write address
  input wire logic awvalid_i, // AXI write address valid
  output logic awready_o, // AXI write address ready
  input wire logic [31:0] wdata_i, // AXI write data
  input wire logic [3:0] wstrb_i, // AXI write strobes
  input wire logic wvalid_i, // AXI write data valid
  output logic wready_o, // AXI write data ready
  output logic [1:0] bresp_o, // AXI write response
  output logic bvalid_o, // AXI write response valid
  input wire logic bready_i, // AXI write response ready
  input wire logic [7:0] araddr_i, // AXI read address
  input wire logic arvalid_i, // AXI read address valid
  output logic arready_o, // AXI read address ready
  output logic [31:0] rdata_o, // AXI read data
  output logic [1:0] rresp_o, // AXI read response
  output logic rvalid_o, // AXI read valid
  input wire logic rready_i, // AXI read ready
  input wire logic [4:0] ext_irq_i, // External interrupt pins
  input wire logic req_valid_i, // Peripheral request, level
  input wire logic [2:0] req_pri_i, // Peripheral group priority
  input wire logic [5:0] req_vec_i, // Peripheral vector number
  input wire logic core_ack_i, // Core takes presented request
  output logic core_req_o, // Request to core, level
  output logic [5:0] core_vec_o, // Vector given to core
  output logic [2:0] core_pri_o, // Priority given to core
  output logic core_shadow_o, // Shadow set goes with vector
  output logic core_multi_vec_o, // Multi-vector mode in force
  output logic irq_o // Unmasked event interrupt
);

  // All registered state; one copy is built, one is registered
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] stat_pri;
    logic [5:0] vec;
    logic [31:0] reload;
    logic [2:0] flags;
    logic [2:0] mask;
    logic irq;
    logic [4:0] ext_pend;
    irq_ctl_pkg::ctl_state_t st;
    logic req;
    logic [5:0] core_vec;
    logic [2:0] core_pri;
    logic shadow;
    logic multi_vec;
    logic sel_ext;
    logic [2:0] sel_idx;
    logic start;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } top_state_t;

  top_state_t r, n;
  prox_timer_if tif();
  logic [4:0] edge_hit;

  // Field widths used by the decode; the event width follows the package
  localparam int EV_BITS = irq_ctl_pkg::EV_W;
  localparam int TRIG_W = 3;
  localparam int PRI_W = 3;
  localparam int VEC_W = 6;
  localparam int LANES = 4;

  // Candidate chosen by the arbiter
  logic cand_ok;
  logic cand_ext;
  logic [2:0] cand_idx;
  logic [2:0] cand_pri;
  logic [5:0] cand_vec;
  logic cand_qual;
  logic [2:0] trig;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] bmask;
  logic [31:0] wsel;
  logic [EV_BITS-1:0] ev_set;
  logic [EV_BITS-1:0] ev_clr;
  logic [4:0] pend_clr;

  // Pin synchroniser and polarity-selected edge detect
  ext_edge_detect ext_edge_detect_inst (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(ext_irq_i),
    .pol_i(r.ctrl[irq_ctl_pkg::EDGE_LSB +: irq_ctl_pkg::NUM_EXT]),
    .edge_o(edge_hit)
  );

  // Proximity down-counter behind its interface
  prox_timer prox_timer_inst (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .tif(tif.tmr)
  );

  // Timer hookup and the trigger level field
  assign tif.start = r.start;
  assign tif.reload = r.reload;
  assign trig = r.ctrl[irq_ctl_pkg::TRIG_LSB +: TRIG_W];

  // Byte-lane mask from the stored strobes
  genvar b;
  generate
    for (b = 0; b < LANES; b++) begin : g_lane
      assign bmask[b*8 +: 8] = {8{r.wstrb[b]}};
    end
  endgenerate
  assign wsel = r.wdata & bmask;

  // Arbiter: peripheral wins only above the external priority
  // Among the pins the lowest index wins, as the loop runs downward
  always_comb begin
    cand_ok = 1'b0;
    cand_ext = 1'b0;
    cand_idx = 3'h0;
    cand_pri = irq_ctl_pkg::PRI_NONE;
    cand_vec = irq_ctl_pkg::SINGLE_VEC;
    for (int i = irq_ctl_pkg::NUM_EXT - 1; i >= 0; i--) begin
      if (r.ext_pend[i]) begin
        cand_ok = 1'b1;
        cand_ext = 1'b1;
        cand_idx = 3'(i);
        cand_pri = irq_ctl_pkg::EXT_PRIORITY;
        cand_vec = irq_ctl_pkg::EXT_VEC_BASE + 6'(i);
      end
    end
    if (req_valid_i && req_pri_i != irq_ctl_pkg::PRI_NONE &&
        (!cand_ok || req_pri_i > irq_ctl_pkg::EXT_PRIORITY)) begin
      cand_ok = 1'b1;
      cand_ext = 1'b0;
      cand_idx = 3'h0;
      cand_pri = req_pri_i;
      cand_vec = req_vec_i;
    end
  end

  // Timer qualification; a zero reload would wrap the timer and defer for about 2^32 cycles
  assign cand_qual = (trig != 3'h0) && (cand_pri <= trig) &&
                     (r.reload != 32'h0000_0000);

  // Read mux; unused bits come back as zero
  // Decoded from the live address so data is ready at the take edge
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (araddr_i)
      irq_ctl_pkg::CTRL_OFF: rd_word = r.ctrl & irq_ctl_pkg::CTRL_WMASK;
      irq_ctl_pkg::STAT_OFF: begin
        rd_word[irq_ctl_pkg::PRI_LSB +: PRI_W] = r.stat_pri;
        rd_word[irq_ctl_pkg::VEC_LSB +: VEC_W] = r.vec;
      end
      irq_ctl_pkg::RELOAD_OFF: rd_word = r.reload;
      irq_ctl_pkg::FLAG_OFF: rd_word[EV_BITS-1:0] = r.flags;
      irq_ctl_pkg::MASK_OFF: rd_word[EV_BITS-1:0] = r.mask;
      default: rd_hit = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    n = r;
    n.start = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    pend_clr = '0;

    // Write channel capture, address and data in either order
    if (awvalid_i && r.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr_i;
    end
    if (wvalid_i && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata_i;
      n.wstrb = wstrb_i;
    end

    // Register write once both halves are held
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = irq_ctl_pkg::RESP_OKAY;
      unique case (r.aw_addr)
        irq_ctl_pkg::CTRL_OFF: begin
          n.ctrl = ((r.ctrl & ~bmask) | wsel) &
                   irq_ctl_pkg::CTRL_WMASK;
        end
        irq_ctl_pkg::STAT_OFF: begin
          // Hardware owns the status word; writes are dropped
        end
        irq_ctl_pkg::RELOAD_OFF: n.reload = (r.reload & ~bmask) | wsel;
        irq_ctl_pkg::FLAG_OFF: ev_clr = wsel[EV_BITS-1:0];
        irq_ctl_pkg::MASK_OFF: begin
          n.mask = (r.mask & ~bmask[EV_BITS-1:0]) | wsel[EV_BITS-1:0];
        end
        default: n.bresp = irq_ctl_pkg::RESP_SLVERR;
      endcase
    end
    // Response leaves on its handshake
    if (r.bvalid && bready_i) begin
      n.bvalid = 1'b0;
    end

    // Read channel: one read at a time
    if (arvalid_i && r.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = rd_hit ? irq_ctl_pkg::RESP_OKAY : irq_ctl_pkg::RESP_SLVERR;
    end
    // Read data leaves on its handshake
    if (r.rvalid && rready_i) begin
      n.rvalid = 1'b0;
    end
    // Readies stay low while a transfer is held or answered
    n.arready = !n.rvalid;
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Presentation sequence; a deferred request is checked again at expiry,
    // so a source that withdrew while the timer ran sends nothing
    unique case (r.st)
      irq_ctl_pkg::ST_IDLE: begin
        if (cand_ok) begin
          if (cand_qual && !tif.busy) begin
            n.start = 1'b1;
            n.st = irq_ctl_pkg::ST_DEFER;
          end else begin
            n.st = irq_ctl_pkg::ST_PRESENT;
          end
        end
      end
      irq_ctl_pkg::ST_DEFER: begin
        if (tif.done) begin
          ev_set[irq_ctl_pkg::EV_PROX] = 1'b1;
          n.st = cand_ok ? irq_ctl_pkg::ST_PRESENT : irq_ctl_pkg::ST_IDLE;
        end
      end
      irq_ctl_pkg::ST_PRESENT: begin
        if (core_ack_i) begin
          n.req = 1'b0;
          n.st = irq_ctl_pkg::ST_IDLE;
          if (r.sel_ext) begin
            pend_clr[r.sel_idx] = 1'b1;
          end
        end
      end
      default: n.st = irq_ctl_pkg::ST_IDLE;
    endcase

    // Latch what goes out to the core on entry to presenting
    if (n.st == irq_ctl_pkg::ST_PRESENT && r.st != irq_ctl_pkg::ST_PRESENT) begin
      n.req = 1'b1;
      n.sel_ext = cand_ext;
      n.sel_idx = cand_idx;
      n.core_pri = cand_pri;
      n.stat_pri = cand_pri;
      n.vec = cand_vec;
      n.core_vec = r.ctrl[irq_ctl_pkg::MULTI_VEC_BIT] ? cand_vec :
                   irq_ctl_pkg::SINGLE_VEC;
      n.shadow = !r.ctrl[irq_ctl_pkg::MULTI_VEC_BIT] &&
                 r.ctrl[irq_ctl_pkg::SHADOW_BIT];
      ev_set[irq_ctl_pkg::EV_PRESENT] = 1'b1;
    end
    // Mode copy for the core, one cycle behind the control bit
    n.multi_vec = r.ctrl[irq_ctl_pkg::MULTI_VEC_BIT];

    // Pending external edges; a new edge beats the acknowledge
    n.ext_pend = (r.ext_pend & ~pend_clr) | edge_hit;
    ev_set[irq_ctl_pkg::EV_EXT] = |edge_hit;

    // Sticky flags; set wins over a one written to clear
    n.flags = (r.flags & ~ev_clr) | ev_set;
    n.irq = |(n.flags & n.mask);
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.ctrl <= irq_ctl_pkg::CTRL_RESET;
      r.st <= irq_ctl_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign awready_o = r.awready;
  assign wready_o = r.wready;
  assign bresp_o = r.bresp;
  assign bvalid_o = r.bvalid;
  assign arready_o = r.arready;
  assign rdata_o = r.rdata;
  assign rresp_o = r.rresp;
  assign rvalid_o = r.rvalid;
  assign core_req_o = r.req;
  assign core_vec_o = r.core_vec;
  assign core_pri_o = r.core_pri;
  assign core_shadow_o = r.shadow;
  assign core_multi_vec_o = r.multi_vec;
  assign irq_o = r.irq;

endmodule : irq_control_and_status

`default_nettype wire

// >>> test/core_model.sv
/*
  Behavioural processor core: takes each presented request after a
  chosen number of cycles. Assumes the controller's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Reset, active low
  input wire logic req_i, // Presented request
  input wire logic [3:0] delay_i, // Wait before ack
  output logic ack_o // One-cycle ack
);
  logic [3:0] cnt_reg;

  // One ack per request; a slow core shows whether the vector is held
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !req_i || ack_o) begin
      cnt_reg <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      ack_o <= (cnt_reg >= delay_i);
    end
  end
endmodule : core_model

`default_nettype wire

// >>> test/irq_ctl_sva.sv
/*
  Port checker of the interrupt control block.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_ctl_sva (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic awvalid_i, // AW valid
  input wire logic awready_o, // AW ready
  input wire logic wvalid_i, // W valid
  input wire logic wready_o, // W ready
  input wire logic bvalid_o, // B valid
  input wire logic bready_i, // B ready
  input wire logic [7:0] araddr_i, // AR address
  input wire logic arvalid_i, // AR valid
  input wire logic arready_o, // AR ready
  input wire logic [31:0] rdata_o, // Read data
  input wire logic [1:0] rresp_o, // Read response
  input wire logic rvalid_o, // R valid
  input wire logic rready_i, // R ready
  input wire logic core_req_o, // Core request
  input wire logic core_ack_i, // Core ack
  input wire logic [5:0] core_vec_o, // Vector
  input wire logic [2:0] core_pri_o, // Priority
  input wire logic core_shadow_o, // Shadow set
  input wire logic core_multi_vec_o // Multi-vector mode
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_B_HOLD: assert property (bvalid_o && !bready_i |=> bvalid_o)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid_o && !rready_i |=>
    rvalid_o && $stable(rdata_o)) else $error("read data not held");
  AST_W_ANSWER: assert property (awvalid_i && awready_o && wvalid_i &&
    wready_o |-> ##[1:2] bvalid_o) else $error("no write response");
  AST_UNMAPPED: assert property (arvalid_i && arready_o &&
    araddr_i > 8'h10 |-> ##[1:2] rvalid_o && rresp_o == 2'h2 &&
    rdata_o == 32'h0000_0000) else $error("bad unmapped read");
  AST_REQ_HOLD: assert property (core_req_o && !core_ack_i |=>
    core_req_o && $stable(core_vec_o) && $stable(core_pri_o))
    else $error("request changed before ack");
  AST_ACK_DROP: assert property (core_req_o && core_ack_i |=> !core_req_o)
    else $error("request stands after ack");
  AST_SINGLE_VEC: assert property ($rose(core_req_o) &&
    !core_multi_vec_o |-> core_vec_o == 6'h00)
    else $error("single vector not zero");
  AST_SHADOW: assert property ($rose(core_req_o) &&
    core_multi_vec_o |-> !core_shadow_o)
    else $error("shadow in multi-vector mode");
  AST_PRI_SET: assert property ($rose(core_req_o)
    |-> core_pri_o != 3'h0) else $error("request with no priority");
endmodule : irq_ctl_sva

bind irq_control_and_status irq_ctl_sva irq_ctl_sva_inst (.*);

`default_nettype wire

// >>> test/tb_irq_control_and_status.sv
/*
  Self-checking bench of the interrupt control block.
  Assumes the core model acknowledges every presented request.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_irq_control_and_status;
  logic ref_clk_i, rstn_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
  logic rready_i, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic req_valid_i, core_ack_i, core_req_o, core_shadow_o;
  logic core_multi_vec_o, irq_o;
  logic [7:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o, rd;
  logic [3:0] wstrb_i, ack_delay;
  logic [1:0] bresp_o, rresp_o, resp;
  logic [4:0] ext_irq_i;
  logic [2:0] req_pri_i, core_pri_o;
  logic [5:0] req_vec_i, core_vec_o;
  int n_fail, n_compared, n;

  irq_control_and_status irq_control_and_status_inst (.*);
  core_model core_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .req_i(core_req_o), .delay_i(ack_delay), .ack_o(core_ack_i));

  // Clock, 100 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic tmo(input int lim);
    if (n >= lim) begin
      chk("wait_bound", 32'h0000_0001, 32'h0000_0000);
      print_verdict();
    end
  endtask : tmo

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o === 1'b1) break;
    end
    bready_i <= 1'b0;
    resp = bresp_o;
    tmo(40);
  endtask : wr

  task automatic rdw(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o === 1'b1) break;
    end
    rready_i <= 1'b0;
    d = rdata_o;
    resp = rresp_o;
    tmo(40);
  endtask : rdw

  // Counts edges until a request is seen; n equals lim if none came
  task automatic wait_req(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge ref_clk_i);
      if (core_req_o === 1'b1) break;
    end
  endtask : wait_req

  // An edge first, so a drop by done_req is not overwritten in its step
  task automatic present(input logic [2:0] p, input logic [5:0] v);
    @(posedge ref_clk_i);
    req_pri_i <= p;
    req_vec_i <= v;
    req_valid_i <= 1'b1;
    wait_req(40);
    tmo(40);
  endtask : present

  // Peripheral drops its request at the ack edge
  task automatic done_req();
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (core_ack_i === 1'b1) break;
    end
    req_valid_i <= 1'b0;
    tmo(40);
  endtask : done_req

  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      rdw(8'(4 * i), rd);
      chk("reset_value", rd, 32'h0000_0000);
    end
    wr(irq_ctl_pkg::CTRL_OFF, 32'hFFFF_FFFF);
    rdw(irq_ctl_pkg::CTRL_OFF, rd);
    chk("ctrl_unused", rd, 32'h0001_171F);
    wr(irq_ctl_pkg::STAT_OFF, 32'hFFFF_FFFF);
    rdw(irq_ctl_pkg::STAT_OFF, rd);
    chk("status_ro", rd, 32'h0000_0000);
    wr(irq_ctl_pkg::RELOAD_OFF, 32'hA5A5_5A5A);
    rdw(irq_ctl_pkg::RELOAD_OFF, rd);
    chk("reload", rd, 32'hA5A5_5A5A);
    wr(8'h20, 32'h0000_0001);
    chk("wr_unmapped", resp, 2'h2);
    rdw(8'h20, rd);
    chk("rd_unmapped", resp, 2'h2);
  endtask : t_regs

  // Single vector with shadow set, slow core, then multi-vector
  task automatic t_vectors();
    wr(irq_ctl_pkg::CTRL_OFF, 32'h0001_0000);
    ack_delay <= 4'h5;
    present(3'h2, 6'h09);
    chk("single_vec", core_vec_o, 6'h00);
    chk("shadow_on", core_shadow_o, 1'b1);
    chk("pri", core_pri_o, 3'h2);
    done_req();
    rdw(irq_ctl_pkg::STAT_OFF, rd);
    chk("status", rd, 32'h0000_0209);
    wr(irq_ctl_pkg::CTRL_OFF, 32'h0001_1000);
    ack_delay <= 4'h0;
    present(3'h5, 6'h2A);
    chk("multi_vec_vector", core_vec_o, 6'h2A);
    chk("multi_vec_flag", core_multi_vec_o, 1'b1);
    chk("shadow_off", core_shadow_o, 1'b0);
    done_req();
  endtask : t_vectors

  // Each pin, rising then falling polarity; wrong edges must stay quiet
  task automatic t_ext();
    for (int i = 0; i < 5; i++) begin
      for (int p = 1; p >= 0; p--) begin
        wr(irq_ctl_pkg::CTRL_OFF, 32'h0000_1000 | (32'(p) << i));
        ext_irq_i[i] <= ~p[0];
        wait_req(8);
        chk("ext_wrong_edge", n, 8);
        ext_irq_i[i] <= p[0];
        wait_req(8);
        chk("ext_seen", 32'(n < 8), 1);
        chk("ext_vec", core_vec_o, 6'(3 + i));
        chk("ext_pri", core_pri_o, 3'h4);
        done_req();
        ext_irq_i[i] <= 1'b0;
        wait_req(8);
        chk("ext_back_edge", n, 8);
      end
    end
  endtask : t_ext

  task automatic t_prox();
    wr(irq_ctl_pkg::RELOAD_OFF, 32'h0000_0014);
    for (int lv = 1; lv <= 2; lv++) begin
      wr(irq_ctl_pkg::CTRL_OFF, 32'(lv) << 8);
      present(3'(lv), 6'h11);
      chk("deferred", 32'(n >= 20 && n <= 30), 1);
      done_req();
      present(3'(lv + 1), 6'h11);
      chk("above_level", 32'(n <= 3), 1);
      done_req();
    end
    wr(irq_ctl_pkg::CTRL_OFF, 32'h0000_0000);
    present(3'h1, 6'h11);
    chk("timer_off", 32'(n <= 3), 1);
    done_req();
  endtask : t_prox

  task automatic t_irq();
    wr(irq_ctl_pkg::FLAG_OFF, 32'h0000_0007);
    wr(irq_ctl_pkg::MASK_OFF, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_clear", irq_o, 1'b0);
    present(3'h3, 6'h05);
    done_req();
    repeat (2) @(posedge ref_clk_i);
    chk("irq_set", irq_o, 1'b1);
    wr(irq_ctl_pkg::MASK_OFF, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_masked", irq_o, 1'b0);
    rdw(irq_ctl_pkg::FLAG_OFF, rd);
    chk("flag_sticky", rd, 32'h0000_0001);
    wr(irq_ctl_pkg::MASK_OFF, 32'h0000_0001);
    wr(irq_ctl_pkg::FLAG_OFF, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_w1c", irq_o, 1'b0);
  endtask : t_irq

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h00;
    {awaddr_i, araddr_i, wdata_i} = 48'h0;
    wstrb_i = 4'hF;
    ext_irq_i = 5'h00;
    {req_valid_i, req_pri_i, req_vec_i} = 10'h000;
    ack_delay = 4'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_vectors();
    t_ext();
    t_prox();
    t_irq();
    print_verdict();
  end
endmodule : tb_irq_control_and_status

`default_nettype wire
